// *** core/lldram_cmd_front.sv ***
`timescale 1ns/1ns
module lldram_cmd_front
    import lldram_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = POWERUP_CYC
)
(
    input logic clk,
    input logic srst,
    input logic ce,
    input cmd_pins_t pins,
    input logic wr_valid,
    input logic write_byte_mask,
    input logic [DATA_W-1:0] wr_data,
    output access_t rd_req,
    output access_t wr_req,
    output refresh_t ref_req,
    output array_write_t arr_wr,
    output logic [MODE_W-1:0] mode_load_bits,
    output logic [CNT_W-1:0] read_latency,
    output logic [CNT_W-1:0] write_latency,
    output logic device_ready,
    output logic [BANKS-1:0] bank_busy,
    output logic reserved_flag,
    output logic mode_busy_flag,
    output logic recal_active
);

    // ************************************************************
    // Command decode and state
    // ************************************************************
    typedef enum logic [2:0] {ST_POWER, ST_MODES, ST_REFRESH, ST_PLL, ST_READY} state_t;

    state_t state_reg, state_next;
    logic [31:0] wait_reg, wait_next;
    logic [1:0] loads_reg, loads_next;
    logic [BANKS-1:0] init_ref_reg, init_ref_next;
    logic [CNT_W-1:0] bank_cnt_reg [BANKS];
    logic [CNT_W-1:0] bank_cnt_next [BANKS];
    logic [CNT_W-1:0] burst_reg, burst_next;
    logic [2:0] mrsc_reg, mrsc_next;
    logic [MODE_W-1:0] mode_reg, mode_next;
    logic [CNT_W-1:0] rl_reg, rl_next, wl_reg, wl_next;
    access_t rd_reg, rd_next, wr_reg, wr_next, wr_addr_reg, wr_addr_next;
    refresh_t ref_reg, ref_next;
    array_write_t arr_reg, arr_next;
    logic ready_reg, ready_next;
    logic [BANKS-1:0] busy_reg, busy_next;
    logic resv_reg, resv_next, mbusy_reg, mbusy_next;
    logic [11:0] recal_cnt_reg, recal_cnt_next;
    logic recal_reg, recal_next;
    cmd_t cmd;
    logic busy;
    logic run;
    logic row_adv;
    logic [ROW_W-1:0] row_now;
    logic [MODE_W-1:0] load_bits;

    assign cmd = decode_cmd(pins);
    assign load_bits = pins.addr[MODE_W-1:0];
    assign run = (state_reg == ST_READY);

    always_comb begin
        busy = (burst_reg != 4'h0);
        for (int i = 0; i < BANKS; i++) begin
            busy = busy || (bank_cnt_reg[i] != 4'h0);
        end
    end

    lldram_refresh_rows u_rows (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .adv(row_adv),
        .bank(pins.bank),
        .row(row_now)
    );

    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        loads_next = loads_reg;
        init_ref_next = init_ref_reg;
        mrsc_next = (mrsc_reg != 3'h0) ? mrsc_reg - 3'h1 : mrsc_reg;
        burst_next = (burst_reg != 4'h0) ? burst_reg - 4'h1 : burst_reg;
        for (int i = 0; i < BANKS; i++) begin
            bank_cnt_next[i] = (bank_cnt_reg[i] != 4'h0) ? bank_cnt_reg[i] - 4'h1 : 4'h0;
        end
        mode_next = mode_reg;
        rl_next = rl_reg;
        wl_next = wl_reg;
        rd_next = '0;
        wr_next = '0;
        ref_next = '0;
        wr_addr_next = wr_addr_reg;
        resv_next = 1'b0;
        mbusy_next = 1'b0;
        row_adv = 1'b0;
        // deselect decodes to idle, nothing taken
        case (cmd)
            CMD_MODE: begin
                if (state_reg != ST_POWER) begin
                    mbusy_next = busy;
                    if (mode_ok(load_bits)) begin
                        mode_next = load_bits;
                        mrsc_next = MRSC_CYC;
                        rl_next = trc_of(load_bits[CFG_LSB +: CFG_W]);
                        wl_next = trc_of(load_bits[CFG_LSB +: CFG_W]) + 4'h1;
                        burst_next = 4'h0;
                        for (int i = 0; i < BANKS; i++) begin
                            bank_cnt_next[i] = 4'h0;
                        end
                    end else begin
                        resv_next = run;
                    end
                end
            end
            CMD_READ: begin
                if (run) begin
                    rd_next = '{valid: 1'b1, bank: pins.bank, addr: pins.addr};
                    bank_cnt_next[pins.bank] = rl_reg;
                    burst_next = rl_reg + beats_of(mode_reg[BL_LSB +: BL_W]);
                end
            end
            CMD_WRITE: begin
                if (run) begin
                    wr_next = '{valid: 1'b1, bank: pins.bank, addr: pins.addr};
                    wr_addr_next = wr_next;
                    bank_cnt_next[pins.bank] = rl_reg;
                    burst_next = wl_reg + beats_of(mode_reg[BL_LSB +: BL_W]);
                end
            end
            CMD_REF: begin
                if (run || state_reg == ST_REFRESH) begin
                    ref_next = '{valid: 1'b1, bank: pins.bank, row: row_now};
                    row_adv = 1'b1;
                    bank_cnt_next[pins.bank] = rl_reg;
                    init_ref_next[pins.bank] = 1'b1;
                end
            end
            default: begin
            end
        endcase
        case (state_reg)
            ST_POWER: begin
                wait_next = wait_reg + 32'h1;
                if (wait_reg >= POWERUP_CYCLES - 1) begin
                    state_next = ST_MODES;
                    wait_next = 32'h0;
                end
            end
            ST_MODES: begin
                // dummy loads then a valid one
                if (cmd == CMD_MODE) begin
                    if (loads_reg >= DUMMY_LOADS && mode_ok(load_bits)) begin
                        state_next = ST_REFRESH;
                    end else if (loads_reg < DUMMY_LOADS) begin
                        loads_next = loads_reg + 2'h1;
                    end
                end else if (cmd != CMD_IDLE) begin
                    loads_next = 2'h0;
                end
            end
            ST_REFRESH: begin
                if (init_ref_next == '1) begin
                    state_next = ST_PLL;
                    wait_next = 32'h0;
                end
            end
            ST_PLL: begin
                // lock time and row cycle before ready
                wait_next = wait_reg + 32'h1;
                if (wait_reg >= PLL_LOCK_CYC - 1 && !busy) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
            end
            default: begin
                state_next = ST_POWER;
            end
        endcase
        arr_next = '{en: wr_valid && !write_byte_mask && run, bank: wr_addr_reg.bank,
                     addr: wr_addr_reg.addr, data: wr_data};
        ready_next = (state_next == ST_READY);
        for (int i = 0; i < BANKS; i++) begin
            busy_next[i] = (bank_cnt_next[i] != 4'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_POWER;
            wait_reg <= 32'h0;
            loads_reg <= 2'h0;
            init_ref_reg <= '0;
            bank_cnt_reg <= '{default: '0};
            burst_reg <= 4'h0;
            mrsc_reg <= 3'h0;
            mode_reg <= MODE_RESET;
            rl_reg <= trc_of(MODE_RESET[CFG_LSB +: CFG_W]);
            wl_reg <= trc_of(MODE_RESET[CFG_LSB +: CFG_W]) + 4'h1;
            rd_reg <= '0;
            wr_reg <= '0;
            wr_addr_reg <= '0;
            ref_reg <= '0;
            arr_reg <= '0;
            ready_reg <= 1'b0;
            busy_reg <= '0;
            resv_reg <= 1'b0;
            mbusy_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            loads_reg <= loads_next;
            init_ref_reg <= init_ref_next;
            bank_cnt_reg <= bank_cnt_next;
            burst_reg <= burst_next;
            mrsc_reg <= mrsc_next;
            mode_reg <= mode_next;
            rl_reg <= rl_next;
            wl_reg <= wl_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            wr_addr_reg <= wr_addr_next;
            ref_reg <= ref_next;
            arr_reg <= arr_next;
            ready_reg <= ready_next;
            busy_reg <= busy_next;
            resv_reg <= resv_next;
            mbusy_reg <= mbusy_next;
        end
    end

    // ************************************************************
    // Output impedance recalibration
    // ************************************************************
    // runs beside commands, gates nothing
    always_comb begin
        recal_cnt_next = (recal_cnt_reg == RECAL_PERIOD) ? 12'h000 : recal_cnt_reg + 12'h001;
        recal_next = (recal_cnt_next < RECAL_LEN);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            recal_cnt_reg <= 12'h000;
            recal_reg <= 1'b0;
        end else if (ce) begin
            recal_cnt_reg <= recal_cnt_next;
            recal_reg <= recal_next;
        end
    end

    assign rd_req = rd_reg;
    assign wr_req = wr_reg;
    assign ref_req = ref_reg;
    assign arr_wr = arr_reg;
    assign mode_load_bits = mode_reg;
    assign read_latency = rl_reg;
    assign write_latency = wl_reg;
    assign device_ready = ready_reg;
    assign bank_busy = busy_reg;
    assign reserved_flag = resv_reg;
    assign mode_busy_flag = mbusy_reg;
    assign recal_active = recal_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_read_taken;
        ce && run && cmd == CMD_READ;
    endsequence
    sequence s_write_taken;
        ce && run && cmd == CMD_WRITE;
    endsequence
    sequence s_good_load;
        ce && state_reg != ST_POWER && cmd == CMD_MODE && mode_ok(load_bits);
    endsequence

    property p_desel;
        ce && pins.cs_n |=> !rd_reg.valid && !wr_reg.valid && !ref_reg.valid;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect took a command");

    property p_keep;
        ce && cmd == CMD_IDLE && burst_reg > 4'h1 |=> burst_reg == $past(burst_reg) - 4'h1;
    endproperty
    a_keep: assert property (p_keep) else $error("burst disturbed by idle");

    property p_read;
        s_read_taken |=> rd_reg.valid && rd_reg.bank == $past(pins.bank)
            && rd_reg.addr == $past(pins.addr) && busy_reg[rd_reg.bank];
    endproperty
    a_read: assert property (p_read) else $error("read not started");

    property p_write;
        s_write_taken |=> wr_reg.valid && wr_reg.addr == $past(pins.addr)
            && wr_addr_reg.bank == $past(pins.bank);
    endproperty
    a_write: assert property (p_write) else $error("write not started");

    property p_mask;
        ce && wr_valid && write_byte_mask |=> !arr_reg.en;
    endproperty
    a_mask: assert property (p_mask) else $error("masked word written");

    property p_ref;
        ce && cmd == CMD_REF && run |=> ref_reg.valid && ref_reg.bank == $past(pins.bank)
            && ref_reg.row == $past(row_now);
    endproperty
    a_ref: assert property (p_ref) else $error("refresh wrong bank or row");

    property p_mode;
        s_good_load |=> mode_reg == $past(load_bits) && mrsc_reg == MRSC_CYC && !busy;
    endproperty
    a_mode: assert property (p_mode) else $error("mode load not stored");

    property p_lat;
        wl_reg == rl_reg + 4'h1 && rl_reg == trc_of(mode_reg[CFG_LSB +: CFG_W]);
    endproperty
    a_lat: assert property (p_lat) else $error("latency mismatch");

    property p_mbusy;
        ce && state_reg != ST_POWER && cmd == CMD_MODE && busy |=> mbusy_reg;
    endproperty
    a_mbusy: assert property (p_mbusy) else $error("busy mode load not flagged");

    property p_resv;
        ce && run && cmd == CMD_MODE && !mode_ok(load_bits) |=> resv_reg && $stable(mode_reg);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved load not ignored");

    property p_ready;
        ce && state_reg == ST_PLL && wait_reg < PLL_LOCK_CYC - 1 |=> !ready_reg;
    endproperty
    a_ready: assert property (p_ready) else $error("ready before lock time");

    property p_recal;
        (recal_reg and s_read_taken) |=> rd_reg.valid;
    endproperty
    a_recal: assert property (p_recal) else $error("recalibration blocked read");

endmodule

// *** core/lldram_refresh_rows.sv ***
`timescale 1ns/1ns
module lldram_refresh_rows
    import lldram_pkg::*;
(
    input logic clk,
    input logic srst,
    input logic ce,
    input logic adv,
    input logic [BANK_W-1:0] bank,
    output logic [ROW_W-1:0] row
);

    logic [ROW_W-1:0] rows_reg [BANKS];
    logic [ROW_W-1:0] rows_next [BANKS];

    assign row = rows_reg[bank];

    always_comb begin
        rows_next = rows_reg;
        if (adv) begin
            rows_next[bank] = rows_reg[bank] + 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rows_reg <= '{default: '0};
        end else if (ce) begin
            rows_reg <= rows_next;
        end
    end

endmodule

// *** shared/lldram_pkg.sv ***
// What this block does
// - Deselect leaves running operations undisturbed
// - Chip select high forces internal idle
// - Read starts burst at bank and address
// - Write starts burst at bank and address
// - Masked write words leave array unchanged
// - Refresh uses bank input, internal row
// - Ready after lock time and row cycle following refreshes
// - Impedance recalibration never disturbs operation
// - Mode load stores eighteen address bits
// - Mode load anytime after the power-up wait, pending work abandoned
// - Command encoding from select, write, refresh
// - Config sets row cycle, latencies, write +1
package lldram_pkg;

    localparam int BANK_W = 3;
    localparam int BANKS = 8;
    localparam int ADDR_W = 21;
    localparam int MODE_W = 18;
    localparam int ROW_W = 13;
    localparam int DATA_W = 18;
    localparam int CNT_W = 4;
    localparam int CFG_LSB = 0;
    localparam int CFG_W = 3;
    localparam int BL_LSB = 3;
    localparam int BL_W = 2;
    localparam int ODT_BIT = 9;
    localparam int TEST_LSB = 10;
    localparam int TEST_W = 8;

    localparam logic [BL_W-1:0] BL_TWO = 2'h0;
    localparam logic [BL_W-1:0] BL_FOUR = 2'h1;
    localparam logic [BL_W-1:0] BL_EIGHT = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RESET = 18'h00001;
    localparam logic [2:0] MRSC_CYC = 3'h6;
    localparam logic [1:0] DUMMY_LOADS = 2'h2;

    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned PLL_LOCK_US = 15;
    localparam int unsigned PLL_LOCK_CYC =
        (PLL_LOCK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned POWERUP_US = 200;
    localparam int unsigned POWERUP_CYC =
        (POWERUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] RECAL_PERIOD = 12'hFFF;
    localparam logic [11:0] RECAL_LEN = 12'h010;

    typedef enum logic [2:0] {CMD_IDLE, CMD_MODE, CMD_READ, CMD_WRITE, CMD_REF} cmd_t;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic ref_n;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } cmd_pins_t;

    typedef struct packed {
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } access_t;

    typedef struct packed {
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
    } refresh_t;

    typedef struct packed {
        logic en;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } array_write_t;

    function automatic cmd_t decode_cmd(input cmd_pins_t p);
        if (p.cs_n) begin
            return CMD_IDLE;
        end
        case ({p.we_n, p.ref_n})
            2'h0: return CMD_MODE;
            2'h3: return CMD_READ;
            2'h1: return CMD_WRITE;
            default: return CMD_REF;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] trc_of(input logic [CFG_W-1:0] cfg);
        case (cfg)
            3'h1: return 4'h4;
            3'h2: return 4'h6;
            3'h3: return 4'h8;
            3'h4: return 4'h3;
            default: return 4'h5;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] beats_of(input logic [BL_W-1:0] bl);
        case (bl)
            BL_FOUR: return 4'h2;
            BL_EIGHT: return 4'h4;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic mode_ok(input logic [MODE_W-1:0] m);
        logic [CFG_W-1:0] cfg;
        logic [BL_W-1:0] bl;
        cfg = m[CFG_LSB +: CFG_W];
        bl = m[BL_LSB +: BL_W];
        return (m[TEST_LSB +: TEST_W] == 8'h00) && (cfg >= 3'h1) && (cfg <= 3'h5)
            && (bl != 2'h3) && !(bl == BL_EIGHT && (cfg == 3'h1 || cfg == 3'h4));
    endfunction

endpackage

// *** testbench/lldram_ctrl_model.sv ***
`timescale 1ns/1ns
module lldram_ctrl_model
    import lldram_pkg::*;
(
    input wire logic clk,
    output cmd_pins_t pins
);
    cmd_pins_t last;

    initial begin
        last = cmd_pins_t'(27'h0000000);
        pins = cmd_pins_t'({1'b1, 26'h0000000});
    end

    // ****************************************
    // Command issue
    // ****************************************
    // command pin encoding
    task automatic issue(input logic we_n, input logic ref_n,
                         input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr);
        @(posedge clk);
        last = {1'b0, we_n, ref_n, bank, addr};
        pins <= last;
        @(posedge clk);
        pins <= {1'b1, ~last[25:0]};
    endtask

    task automatic mode(input logic [MODE_W-1:0] bits);
        repeat (16) @(posedge clk);
        issue(1'b0, 1'b0, 3'h0, {3'h0, bits});
        repeat (MRSC_CYC) @(posedge clk);
    endtask

    task automatic refresh(input logic [BANK_W-1:0] bank);
        issue(1'b1, 1'b0, bank, 21'h1FFFFF);
        repeat (8) @(posedge clk);
    endtask

    task automatic init(input int pwr);
        repeat (pwr) @(posedge clk);
        mode(18'h00000);
        mode(18'h00000);
        mode(MODE_RESET);
        refresh_group();
    endtask

    task automatic refresh_group();
        for (int b = 0; b < BANKS; b++) begin
            issue(1'b1, 1'b0, b[BANK_W-1:0], 21'h000000);
        end
    endtask

    // clock runs lock time after stop
    task automatic restart();
        repeat (PLL_LOCK_CYC) @(posedge clk);
    endtask
endmodule

// *** testbench/tb_lldram_cmd_front.sv ***
`timescale 1ns/1ns
module tb_lldram_cmd_front import lldram_pkg::*; ();
    localparam int PWR = 20;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic wr_valid = 1'b0;
    logic write_byte_mask = 1'b0;
    logic [DATA_W-1:0] wr_data = 18'h00000;
    cmd_pins_t pins;
    access_t rd_req, wr_req, rd_seen, wr_seen;
    refresh_t ref_req, ref_seen;
    array_write_t arr_wr, arr_seen;
    logic [MODE_W-1:0] mode_load_bits;
    logic [CNT_W-1:0] read_latency, write_latency;
    logic device_ready, reserved_flag, mode_busy_flag, recal_active;
    logic [BANKS-1:0] bank_busy;
    logic [3:0] rc [5] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    logic [MODE_W-1:0] bad [5] = '{18'h00401, 18'h00011, 18'h00014, 18'h00006, 18'h00019};
    int errors = 0;
    int samples_checked = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    int ref_cnt = 0;
    int arr_cnt = 0;
    int rsv_cnt = 0;
    int busy_cnt = 0;

    always #2 clk = ~clk;

    lldram_ctrl_model lldram_ctrl_model_i (.clk(clk), .pins(pins));

    lldram_cmd_front #(.POWERUP_CYCLES(PWR)) lldram_cmd_front_i (
        .clk(clk), .srst(srst), .ce(ce), .pins(pins), .wr_valid(wr_valid),
        .write_byte_mask(write_byte_mask), .wr_data(wr_data), .rd_req(rd_req),
        .wr_req(wr_req), .ref_req(ref_req), .arr_wr(arr_wr),
        .mode_load_bits(mode_load_bits), .read_latency(read_latency),
        .write_latency(write_latency), .device_ready(device_ready),
        .bank_busy(bank_busy), .reserved_flag(reserved_flag),
        .mode_busy_flag(mode_busy_flag), .recal_active(recal_active)
    );

    // ****************************************
    // Pulse monitor
    // ****************************************
    always @(posedge clk) begin
        if (rd_req.valid === 1'b1) begin
            rd_seen = rd_req;
            rd_cnt++;
        end
        if (wr_req.valid === 1'b1) begin
            wr_seen = wr_req;
            wr_cnt++;
        end
        if (ref_req.valid === 1'b1) begin
            ref_seen = ref_req;
            ref_cnt++;
        end
        if (arr_wr.en === 1'b1) begin
            arr_seen = arr_wr;
            arr_cnt++;
        end
        rsv_cnt += (reserved_flag === 1'b1);
        busy_cnt += (mode_busy_flag === 1'b1);
    end

    // ****************************************
    // Checking and verdict
    // ****************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic bring_up();
        check(mode_load_bits, 18'h00001);
        check({read_latency, write_latency}, 8'h45);
        check({device_ready, bank_busy}, 9'h000);
        lldram_ctrl_model_i.issue(1'b1, 1'b1, 3'h3, 21'h012345);
        lldram_ctrl_model_i.init(PWR);
        for (int i = 0; i < 5000 && device_ready !== 1'b1; i++) begin
            settle(1);
        end
        check(device_ready, 1'b1);
        check(rd_cnt, 0);
        check(ref_cnt, 8);
        check(ref_seen, {1'b1, 3'h7, 13'h0000});
    endtask

    task automatic read_write();
        lldram_ctrl_model_i.issue(1'b1, 1'b1, 3'h5, 21'h1ABCDE);
        #1;
        check(bank_busy[5], 1'b1);
        settle(2);
        check(bank_busy[5], 1'b1);
        check(rd_seen, {1'b1, 3'h5, 21'h1ABCDE});
        lldram_ctrl_model_i.issue(1'b0, 1'b1, 3'h6, 21'h0F0F0F);
        wr_valid <= 1'b1;
        wr_data <= 18'h2A5A5;
        @(posedge clk);
        write_byte_mask <= 1'b1;
        wr_data <= 18'h11111;
        @(posedge clk);
        wr_valid <= 1'b0;
        write_byte_mask <= 1'b0;
        settle(3);
        check(wr_seen, {1'b1, 3'h6, 21'h0F0F0F});
        check(arr_cnt, 1);
        check(arr_seen, {1'b1, 3'h6, 21'h0F0F0F, 18'h2A5A5});
    endtask

    task automatic deselect_and_freeze();
        int r;
        r = rd_cnt + wr_cnt + ref_cnt + rsv_cnt;
        @(posedge clk);
        ce <= 1'b0;
        lldram_ctrl_model_i.issue(1'b1, 1'b1, 3'h2, 21'h000777);
        ce <= 1'b1;
        lldram_ctrl_model_i.restart();
        settle(6);
        check(rd_cnt + wr_cnt + ref_cnt + rsv_cnt, r);
    endtask

    task automatic refresh_rows();
        lldram_ctrl_model_i.refresh(3'h2);
        check(ref_seen, {1'b1, 3'h2, 13'h0001});
        lldram_ctrl_model_i.refresh(3'h2);
        check(ref_seen, {1'b1, 3'h2, 13'h0002});
        check(ref_cnt, 10);
    endtask

    task automatic mode_table();
        logic [MODE_W-1:0] m;
        int r;
        for (int c = 1; c <= 5; c++) begin
            m = {13'h0000, (c == 1 || c == 4) ? 2'h0 : 2'h2, c[2:0]};
            lldram_ctrl_model_i.mode(m);
            check(mode_load_bits, m);
            check({read_latency, write_latency}, {rc[c-1], rc[c-1] + 4'h1});
        end
        for (int k = 0; k < 5; k++) begin
            r = rsv_cnt;
            lldram_ctrl_model_i.mode(bad[k]);
            check(rsv_cnt, r + 1);
            check(mode_load_bits, 18'h00015);
        end
        lldram_ctrl_model_i.issue(1'b0, 1'b0, 3'h0, {3'h7, 18'h00001});
        settle(6);
        check(mode_load_bits, 18'h00001);
    endtask

    task automatic load_while_busy();
        lldram_ctrl_model_i.issue(1'b1, 1'b1, 3'h1, 21'h000100);
        lldram_ctrl_model_i.issue(1'b0, 1'b0, 3'h0, 21'h000002);
        settle(1);
        check(bank_busy, 8'h00);
        check(mode_load_bits, 18'h00002);
        check(busy_cnt, 1);
        settle(6);
    endtask

    task automatic read_during_recal();
        // Start at the front of a window so it still stands at the check
        for (int i = 0; i < 5000 && recal_active !== 1'b0; i++) begin
            @(posedge clk);
        end
        for (int i = 0; i < 5000 && recal_active !== 1'b1; i++) begin
            @(posedge clk);
        end
        lldram_ctrl_model_i.issue(1'b1, 1'b1, 3'h0, 21'h000055);
        settle(2);
        check(recal_active, 1'b1);
        check(rd_seen, {1'b1, 3'h0, 21'h000055});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        settle(1);
        bring_up();
        read_write();
        deselect_and_freeze();
        refresh_rows();
        mode_table();
        load_while_busy();
        read_during_recal();
        report_and_stop();
    end

    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
endmodule
